//--- hw/acs_top.sv
`timescale 1ns/100ps
`include "acs_map.svh"

module acs_top (
	// Clock, reset, enable
	input wire logic CLOCK,
	input wire logic RST_N,
	input wire logic CE,
	// Register port
	input wire logic [3:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// Start sources
	input wire logic TMR2_OVF,
	input wire logic TMR3_OVF,
	input wire logic EXT_CONVERT_STROBE,
	// Converter core
	input wire logic [9:0] ADC_CODE,
	output logic TRACK,
	output logic CONVERTING,
	// Interrupt
	output logic IRQ
);
	import acs_pkg::*;

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Result word as software sees it
	function automatic logic [15:0] acs_word(input logic [9:0] r, input logic lj, input logic sgn);
		if (lj)
			return {r, 6'h00};
		else
			return {{6{sgn & r[9]}}, r};
	endfunction : acs_word

	// Greater-than, signed for differential data
	function automatic logic acs_gt(input logic [15:0] a, input logic [15:0] b, input logic sgn);
		if (sgn)
			return $signed(a) > $signed(b);
		else
			return a > b;
	endfunction : acs_gt

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	acs_state_t state_r;
	logic [3:0] cnt_r;
	logic en_r, tm_r, lj_r, done_r, win_r, sgn_r, strobe_d_r;
	logic [1:0] sel_r, msk_r, ist_r;
	logic [4:0] div_r;
	logic [15:0] gt_r, lt_r;
	logic [9:0] res_r;
	logic [7:0] rdata_r, rd_val;
	logic tick, busy, start, start_trk, conv_end, match, ctl_wr, ext_rise;
	logic [15:0] word_new, word_cur;

	assign ctl_wr = WR && (ADDR == `ACS_OFF_CTL);
	assign ext_rise = EXT_CONVERT_STROBE && !strobe_d_r;

	// ----------------------------------------
	// Start decode
	// ----------------------------------------
	always_comb
	begin
		start = 1'b0;
		start_trk = 1'b0;
		if (en_r && state_r == ACS_IDLE)
		begin
			case (sel_r)
				`ACS_SEL_SW: start = ctl_wr && WDATA[`ACS_CTL_BUSY];
				`ACS_SEL_T3: start = TMR3_OVF;
				`ACS_SEL_EXT: start = ext_rise;
				`ACS_SEL_T2: start = TMR2_OVF;
				default: start = 1'b0;
			endcase
			// Fixed track window except for the strobe-driven mode
			start_trk = start && tm_r && (sel_r != `ACS_SEL_EXT);
		end
	end

	acs_sar_tick u_tick (
		.clk(CLOCK),
		.rst_n(RST_N),
		.ce(CE),
		.clr(start),
		.div(div_r),
		.tick(tick)
	);

	// ----------------------------------------
	// Sequencer
	// ----------------------------------------
	assign conv_end = (state_r == ACS_CONV) && tick && (cnt_r == `ACS_CONV_LAST);

	// Track then convert, counted in SAR clocks
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			state_r <= ACS_IDLE;
			cnt_r <= `ACS_CNT_ZERO;
		end
		else if (CE)
		begin
			if (!en_r)
				state_r <= ACS_IDLE; // Disabling aborts any conversion
			else
			begin
				case (state_r)
					ACS_IDLE:
					begin
						cnt_r <= `ACS_CNT_ZERO;
						if (start_trk)
							state_r <= ACS_TRACK;
						else if (start)
							state_r <= ACS_CONV;
					end
					ACS_TRACK:
						if (tick)
						begin
							if (cnt_r == `ACS_TRK_LAST)
							begin
								cnt_r <= `ACS_CNT_ZERO;
								state_r <= ACS_CONV;
							end
							else
								cnt_r <= cnt_r + `ACS_CNT_ONE;
						end
					ACS_CONV:
						if (tick)
						begin
							if (conv_end)
								state_r <= ACS_IDLE;
							else
								cnt_r <= cnt_r + `ACS_CNT_ONE;
						end
					default: state_r <= ACS_IDLE;
				endcase
			end
		end
	end

	// Busy covers the fixed track window, whichever source started it
	assign busy = (state_r != ACS_IDLE);
	assign CONVERTING = (state_r == ACS_CONV);
	// Free tracking in normal mode; strobe-low tracking in mode 10
	assign TRACK = en_r && ((state_r == ACS_TRACK) || (state_r == ACS_IDLE &&
		(!tm_r || (sel_r == `ACS_SEL_EXT && !EXT_CONVERT_STROBE))));

	// Strobe history for edge detect; input is synchronous already
	// Resets high so a strobe idling high shows no false edge
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			strobe_d_r <= 1'b1;
		else if (CE)
			strobe_d_r <= EXT_CONVERT_STROBE;
	end

	// ----------------------------------------
	// Result and window compare
	// ----------------------------------------
	assign word_new = acs_word(ADC_CODE, lj_r, sgn_r);
	assign word_cur = acs_word(res_r, lj_r, sgn_r);
	// Limits in order give inside window, reversed give outside
	assign match = acs_gt(lt_r, gt_r, sgn_r) ?
		(acs_gt(word_new, gt_r, sgn_r) && acs_gt(lt_r, word_new, sgn_r)) :
		(acs_gt(word_new, gt_r, sgn_r) || acs_gt(lt_r, word_new, sgn_r));

	// Capture code at the end of conversion
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			res_r <= `ACS_RES_RST;
		else if (CE && conv_end)
			res_r <= ADC_CODE;
	end

	// ----------------------------------------
	// Control and configuration writes
	// ----------------------------------------
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			{en_r, tm_r, sel_r, lj_r} <= 5'h00;
			div_r <= `ACS_DIV_RST;
			sgn_r <= 1'b0;
			gt_r <= `ACS_LIM_RST;
			lt_r <= `ACS_LIM_RST;
			msk_r <= `ACS_MSK_RST;
		end
		else if (CE && WR)
		begin
			case (ADDR)
				`ACS_OFF_CTL:
				begin
					en_r <= WDATA[`ACS_CTL_EN];
					tm_r <= WDATA[`ACS_CTL_TM];
					sel_r <= WDATA[`ACS_CTL_SEL_HI:`ACS_CTL_SEL_LO];
					lj_r <= WDATA[`ACS_CTL_LJ];
				end
				`ACS_OFF_CFG:
				begin
					div_r <= WDATA[`ACS_CFG_DIV_HI:`ACS_CFG_DIV_LO];
					sgn_r <= WDATA[`ACS_CFG_SGN];
				end
				`ACS_OFF_GTH: gt_r[15:8] <= WDATA;
				`ACS_OFF_GTL: gt_r[7:0] <= WDATA;
				`ACS_OFF_LTH: lt_r[15:8] <= WDATA;
				`ACS_OFF_LTL: lt_r[7:0] <= WDATA;
				`ACS_OFF_IMSK: msk_r <= WDATA[1:0];
				default: msk_r <= msk_r;
			endcase
		end
	end

	// ----------------------------------------
	// Flags and interrupt
	// ----------------------------------------
	// Hardware set wins over a software clear in the same cycle
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
		begin
			done_r <= 1'b0;
			win_r <= 1'b0;
		end
		else if (CE)
		begin
			done_r <= conv_end || (ctl_wr ? WDATA[`ACS_CTL_DONE] : done_r);
			win_r <= (conv_end && match) || (ctl_wr ? WDATA[`ACS_CTL_WIN] : win_r);
		end
	end

	// Status cleared by reading it
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			ist_r <= `ACS_MSK_RST;
		else if (CE)
		begin
			ist_r[`ACS_INT_DONE] <= conv_end || (ist_r[`ACS_INT_DONE] && !(RD && ADDR == `ACS_OFF_IST));
			ist_r[`ACS_INT_WIN] <= (conv_end && match) || (ist_r[`ACS_INT_WIN] && !(RD && ADDR == `ACS_OFF_IST));
		end
	end

	assign IRQ = |(ist_r & msk_r);

	// ----------------------------------------
	// Read port
	// ----------------------------------------
	always_comb
	begin
		case (ADDR)
			`ACS_OFF_CTL: rd_val = {en_r, tm_r, done_r, busy, sel_r, win_r, lj_r};
			`ACS_OFF_CFG: rd_val = {div_r, 2'h0, sgn_r};
			`ACS_OFF_RESH: rd_val = word_cur[15:8];
			`ACS_OFF_RESL: rd_val = word_cur[7:0];
			`ACS_OFF_GTH: rd_val = gt_r[15:8];
			`ACS_OFF_GTL: rd_val = gt_r[7:0];
			`ACS_OFF_LTH: rd_val = lt_r[15:8];
			`ACS_OFF_LTL: rd_val = lt_r[7:0];
			`ACS_OFF_IST: rd_val = {6'h00, ist_r};
			`ACS_OFF_IMSK: rd_val = {6'h00, msk_r};
			default: rd_val = `ACS_INT_RSV;
		endcase
	end

	// Data stands only in the cycle after the strobe
	always_ff @(posedge CLOCK or negedge RST_N)
	begin
		if (!RST_N)
			rdata_r <= 8'h00;
		else if (CE)
			rdata_r <= RD ? rd_val : 8'h00;
	end

	assign RDATA = rdata_r;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	property p_done_on_fall;
		@(posedge CLOCK) disable iff (!RST_N) $fell(busy) && en_r |-> done_r;
	endproperty
	a_done_on_fall: assert property (p_done_on_fall) else $error("done flag not set as busy fell");

	property p_busy_conv;
		@(posedge CLOCK) disable iff (!RST_N)
			CE && RD && ADDR == `ACS_OFF_CTL && state_r == ACS_CONV |=> RDATA[`ACS_CTL_BUSY];
	endproperty
	a_busy_conv: assert property (p_busy_conv) else $error("busy low during conversion");

	property p_ext_start;
		@(posedge CLOCK) disable iff (!RST_N)
			CE && en_r && !tm_r && sel_r == `ACS_SEL_EXT && state_r == ACS_IDLE && ext_rise |=> state_r == ACS_CONV;
	endproperty
	a_ext_start: assert property (p_ext_start) else $error("strobe edge did not start conversion");

	property p_t2_start;
		@(posedge CLOCK) disable iff (!RST_N)
			CE && en_r && !tm_r && sel_r == `ACS_SEL_T2 && state_r == ACS_IDLE && TMR2_OVF |=> state_r == ACS_CONV;
	endproperty
	a_t2_start: assert property (p_t2_start) else $error("timer 2 overflow did not start conversion");

	property p_track_len;
		@(posedge CLOCK) disable iff (!RST_N)
			state_r == ACS_CONV && $past(state_r) == ACS_TRACK |-> $past(cnt_r) == `ACS_TRK_LAST && $past(tick);
	endproperty
	a_track_len: assert property (p_track_len) else $error("track window not three SAR clocks");

	property p_t3_track;
		@(posedge CLOCK) disable iff (!RST_N)
			CE && en_r && tm_r && sel_r == `ACS_SEL_T3 && state_r == ACS_IDLE && TMR3_OVF |=> state_r == ACS_TRACK;
	endproperty
	a_t3_track: assert property (p_t3_track) else $error("timer 3 overflow did not start tracking");

	property p_ext_track;
		@(posedge CLOCK) disable iff (!RST_N)
			CE && en_r && tm_r && sel_r == `ACS_SEL_EXT && state_r == ACS_IDLE && ext_rise |=> state_r == ACS_CONV;
	endproperty
	a_ext_track: assert property (p_ext_track) else $error("strobe edge did not end tracking");

	property p_win_sticky;
		@(posedge CLOCK) disable iff (!RST_N) win_r && !(CE && ctl_wr) |=> win_r;
	endproperty
	a_win_sticky: assert property (p_win_sticky) else $error("window flag dropped by itself");

	property p_ljust_low;
		@(posedge CLOCK) disable iff (!RST_N) CE && RD && ADDR == `ACS_OFF_RESL && lj_r |=> RDATA[5:0] == 6'h00;
	endproperty
	a_ljust_low: assert property (p_ljust_low) else $error("left justified low byte not zero");

	property p_win_set;
		@(posedge CLOCK) disable iff (!RST_N) CE && conv_end && match |=> win_r;
	endproperty
	a_win_set: assert property (p_win_set) else $error("window match not flagged");

	property p_zero_write;
		@(posedge CLOCK) disable iff (!RST_N)
			CE && ctl_wr && !WDATA[`ACS_CTL_BUSY] && state_r == ACS_IDLE && sel_r == `ACS_SEL_SW |=> state_r == ACS_IDLE;
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("busy write of zero started a conversion");

endmodule : acs_top

//--- hw/acs_map.svh
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define ACS_OFF_CTL 4'h0
`define ACS_OFF_CFG 4'h1
`define ACS_OFF_RESH 4'h2
`define ACS_OFF_RESL 4'h3
`define ACS_OFF_GTH 4'h4
`define ACS_OFF_GTL 4'h5
`define ACS_OFF_LTH 4'h6
`define ACS_OFF_LTL 4'h7
`define ACS_OFF_IST 4'h8
`define ACS_OFF_IMSK 4'h9

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define ACS_CTL_EN 7
`define ACS_CTL_TM 6
`define ACS_CTL_DONE 5
`define ACS_CTL_BUSY 4
`define ACS_CTL_SEL_HI 3
`define ACS_CTL_SEL_LO 2
`define ACS_CTL_WIN 1
`define ACS_CTL_LJ 0

// ----------------------------------------
// Configuration register fields
// ----------------------------------------
`define ACS_CFG_DIV_HI 7
`define ACS_CFG_DIV_LO 3
`define ACS_CFG_SGN 0

// ----------------------------------------
// Interrupt status and mask fields
// ----------------------------------------
`define ACS_INT_DONE 0
`define ACS_INT_WIN 1
`define ACS_INT_RSV 8'h00

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACS_CTL_RST 8'h00
`define ACS_DIV_RST 5'h1F
`define ACS_LIM_RST 16'h0000
`define ACS_RES_RST 10'h000
`define ACS_MSK_RST 2'h0

// ----------------------------------------
// Start source codes
// ----------------------------------------
`define ACS_SEL_SW 2'h0
`define ACS_SEL_T3 2'h1
`define ACS_SEL_EXT 2'h2
`define ACS_SEL_T2 2'h3

// ----------------------------------------
// Phase lengths in SAR clocks
// ----------------------------------------
`define ACS_TRK_LAST 4'h2
`define ACS_CONV_LAST 4'h9
`define ACS_CNT_ZERO 4'h0
`define ACS_CNT_ONE 4'h1

`endif

//--- hw/acs_pkg.sv
package acs_pkg;

	// Sequencer phases
	typedef enum logic [1:0] {
		ACS_IDLE,
		ACS_TRACK,
		ACS_CONV
	} acs_state_t;

endpackage : acs_pkg

//--- hw/acs_sar_tick.sv
`timescale 1ns/100ps
`include "acs_map.svh"

module acs_sar_tick (
	// Clock, reset and enable
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Control
	input wire logic clr,
	input wire logic [4:0] div,
	// SAR clock enable pulse
	output logic tick
);

	logic [4:0] cnt_r;

	// One tick every div+1 system clocks
	assign tick = (cnt_r == div);

	// Restart on clr so every phase starts on a whole SAR clock
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			cnt_r <= 5'h00;
		else if (ce)
		begin
			if (clr || tick)
				cnt_r <= 5'h00;
			else
				cnt_r <= cnt_r + 5'h01;
		end
	end

endmodule : acs_sar_tick

//--- tb/acs_src_model.sv
`timescale 1ns/100ps

// ----------------------------------------
// Timers and external strobe pin
// ----------------------------------------
module acs_src_model (
	// Clock
	input wire logic clk,
	// Start sources
	output logic tmr2_ovf,
	output logic tmr3_ovf,
	output logic ext_strobe
);
	// Strobe idles high so no stray edge
	initial
	begin
		tmr2_ovf = 1'b0;
		tmr3_ovf = 1'b0;
		ext_strobe = 1'b1;
	end

	// One-cycle overflow pulse
	task pulse(input int which);
		@(posedge clk);
		if (which == 2)
			tmr2_ovf <= 1'b1;
		else
			tmr3_ovf <= 1'b1;
		@(posedge clk);
		tmr2_ovf <= 1'b0;
		tmr3_ovf <= 1'b0;
	endtask : pulse

	// Strobe held low for n edges
	task strobe_low(input int n);
		@(posedge clk);
		ext_strobe <= 1'b0;
		repeat (n) @(posedge clk);
	endtask : strobe_low

	// Rising strobe, returns at the taking edge
	task strobe_rise();
		@(posedge clk);
		ext_strobe <= 1'b1;
		@(posedge clk);
	endtask : strobe_rise
endmodule : acs_src_model

//--- tb/acs_top_test.sv
`timescale 1ns/100ps

module acs_top_test;
	logic clock, rst_n, ce, wr, rd, track, conv, irq, t2, t3, stb;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, got;
	logic [9:0] code;
	int err_total, cmp_count, seed, gt, lt, tn, cn;
	bit exp_win;

	// ----------------------------------------
	// Design and source model
	// ----------------------------------------
	acs_top u_dut (.CLOCK(clock), .RST_N(rst_n), .CE(ce), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .TMR2_OVF(t2), .TMR3_OVF(t3), .EXT_CONVERT_STROBE(stb), .ADC_CODE(code),
		.TRACK(track), .CONVERTING(conv), .IRQ(irq));
	acs_src_model u_src (.clk(clock), .tmr2_ovf(t2), .tmr3_ovf(t3), .ext_strobe(stb));

	// 25 MHz clock
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// ----------------------------------------
	// Comparisons and bus cycles
	// ----------------------------------------
	task miss(input string s);
		err_total++;
		$display("wrong value at %0t: %s", $time, s);
	endtask : miss
	task chk_reg(input logic [7:0] g, input logic [7:0] e);
		cmp_count++;
		if (g !== e)
			miss($sformatf("register %h, expected %h", g, e));
	endtask : chk_reg
	task chk_pin(input logic g, input logic e);
		cmp_count++;
		if (g !== e)
			miss($sformatf("pin %b, expected %b", g, e));
	endtask : chk_pin
	task chk_len(input int g, input int e);
		cmp_count++;
		if (g != e)
			miss($sformatf("phase %0d cycles, expected %0d", g, e));
	endtask : chk_len
	task wreg(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask : wreg
	task rchk(input logic [3:0] a, input logic [7:0] e);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 got = rdata;
		chk_reg(got, e);
	endtask : rchk

	// Window model: strict compare, reversed limits mean outside
	function automatic bit win_hit(input int w, input bit sg);
		int a, g, l;
		a = sg ? int'($signed(16'(w))) : w;
		g = sg ? int'($signed(16'(gt))) : gt;
		l = sg ? int'($signed(16'(lt))) : lt;
		return (l > g) ? (a > g && a < l) : (a < l || a > g);
	endfunction : win_hit

	// One conversion: set up, trigger, measure, read back
	task run(input bit tm, input logic [1:0] sel, input bit lj, input bit cfg);
		int dv, m, w;
		bit hit, sg;
		logic [7:0] c;
		dv = {$random(seed)} % 3;
		m = {$random(seed)} % 4;
		gt = {$random(seed)} % 65536;
		lt = {$random(seed)} % 65536;
		sg = 1'($random(seed));
		code <= 10'($random(seed));
		wreg(4'h1, 8'(dv << 3) | {7'h00, sg});
		wreg(4'h9, 8'(m));
		wreg(4'h4, 8'(gt >> 8));
		wreg(4'h5, 8'(gt));
		wreg(4'h6, 8'(lt >> 8));
		wreg(4'h7, 8'(lt));
		c = {1'b1, tm, 2'b00, sel, 1'b0, lj};
		if (cfg || sel == 2'b00)
			exp_win = 1'b0;
		if (cfg)
		begin
			wreg(4'h0, c);
			#1 chk_pin(conv, 1'b0);
		end
		// Wrong source must not start anything
		if (sel != 2'b00)
		begin
			u_src.pulse((sel == 2'b01) ? 2 : 3);
			#1 chk_pin(conv, 1'b0);
		end
		case (sel)
			2'b00: wreg(4'h0, c | 8'h10);
			2'b01: u_src.pulse(3);
			2'b10:
			begin
				u_src.strobe_low(1 + {$random(seed)} % 4);
				#1 if (tm) chk_pin(track, 1'b1);
				u_src.strobe_rise();
			end
			default: u_src.pulse(2);
		endcase
		// Count track and conversion cycles, bounded
		tn = 0;
		cn = 0;
		for (int k = 0; k < 200; k++)
		begin
			#1;
			if (conv === 1'b1)
				cn++;
			else if (cn > 0)
				break;
			else if (track === 1'b1)
				tn++;
			@(posedge clock);
		end
		chk_len(tn, (tm && sel != 2'b10) ? 3 * (dv + 1) : 0);
		chk_len(cn, 10 * (dv + 1));
		w = lj ? int'(code) << 6 : int'({{6{sg & code[9]}}, code});
		hit = win_hit(w, sg);
		exp_win |= hit;
		chk_pin(irq, |(2'(m) & {hit, 1'b1}));
		rchk(4'h0, {1'b1, tm, 1'b1, 1'b0, sel, exp_win, lj});
		rchk(4'h8, {6'h00, hit, 1'b1});
		chk_pin(irq, 1'b0);
		rchk(4'h2, lj ? code[9:2] : {{6{sg & code[9]}}, code[9:8]});
		rchk(4'h3, lj ? {code[1:0], 6'h00} : code[7:0]);
	endtask : run

	// Verdict and end of run
	task close_out();
		$display("comparisons %0d, mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : close_out

	// Watchdog, far beyond the expected run
	initial
	begin
		#(40 * 20000);
		err_total++;
		close_out();
	end

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		seed = 32'hf97f;
		err_total = 0;
		cmp_count = 0;
		rst_n = 1'b0;
		ce = 1'b1;
		wr = 1'b0;
		rd = 1'b0;
		addr = 4'h0;
		wdata = 8'h00;
		code = 10'h000;
		exp_win = 1'b0;
		repeat (4) @(posedge clock);
		rst_n <= 1'b1;
		#1 chk_pin(irq | track | conv, 1'b0);
		rchk(4'h0, 8'h00);
		@(posedge clock);
		#1 chk_reg(rdata, 8'h00);
		rchk(4'h1, 8'hF8);
		rchk(4'h6, 8'h00);
		wreg(4'hF, 8'hFF);
		rchk(4'hF, 8'h00);
		// Every mode, source and justification
		for (int t = 0; t < 2; t++)
			for (int s = 0; s < 4; s++)
				for (int j = 0; j < 2; j++)
					run(t[0], s[1:0], j[0], 1'b1);
		// Window flag accumulates without a clear
		for (int i = 0; i < 6; i++)
			run(1'b0, 2'b11, 1'b0, i == 0);
		// Select software start first: the busy write decodes the select already held
		wreg(4'h1, 8'h08);
		wreg(4'h0, 8'h80);
		wreg(4'h0, 8'h90);
		rchk(4'h0, 8'h90);
		// Ten frozen edges stretch the 20-cycle conversion to end 30 edges after start
		@(posedge clock);
		ce <= 1'b0;
		repeat (10) @(posedge clock);
		ce <= 1'b1;
		repeat (16) @(posedge clock);
		#1 chk_pin(conv, 1'b1);
		@(posedge clock);
		#1 chk_pin(conv, 1'b0);
		rchk(4'h0, 8'hA0 | {6'h00, win_hit(int'(code), 1'b0), 1'b0});
		close_out();
	end
endmodule : acs_top_test
